// [csw_pkg.sv]
package csw_pkg;

  // Clock and internal time base
  localparam int CLK_NS       = 4;
  localparam int TICK_NS      = 1000;
  localparam int TICK_CYC     = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_PER_MS  = 1000000 / TICK_NS;

  // Supervisor times in milliseconds, then in time-base ticks
  localparam int WD_LONG_MS   = 1400;
  localparam int WD_MID_MS    = 600;
  localparam int WD_SHORT_MS  = 200;
  localparam int RST_HOLD_MS  = 200;
  localparam int WR_CYCLE_MS  = 5;
  localparam int WD_LONG_TICKS  = WD_LONG_MS * TICK_PER_MS;
  localparam int WD_MID_TICKS   = WD_MID_MS * TICK_PER_MS;
  localparam int WD_SHORT_TICKS = WD_SHORT_MS * TICK_PER_MS;
  localparam int RST_HOLD_TICKS = RST_HOLD_MS * TICK_PER_MS;
  localparam int WR_CYCLE_TICKS = WR_CYCLE_MS * TICK_PER_MS;

  // Watchdog period codes
  localparam logic [1:0] WD_SEL_LONG  = 2'h0;
  localparam logic [1:0] WD_SEL_MID   = 2'h1;
  localparam logic [1:0] WD_SEL_SHORT = 2'h2;
  localparam logic [1:0] WD_SEL_OFF   = 2'h3;

  // Serial instructions
  localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLR       = 8'h04;
  localparam logic [7:0] OPC_STAT_RD         = 8'h05;
  localparam logic [7:0] OPC_STAT_WR         = 8'h01;
  localparam logic [7:0] OPC_ARR_RD          = 8'h03;
  localparam logic [7:0] OPC_ARR_WR          = 8'h02;
  localparam logic [7:0] OPC_A8_MASK         = 8'hf7;
  localparam int         OPC_A8_BIT          = 3;

  // Status byte layout
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_LATCH_BIT = 1;
  localparam int         ST_CTRL_LSB  = 2;
  localparam int         CTRL_W       = 4;
  localparam logic [3:0] CTRL_RESET   = 4'h0;

  // Array geometry and lock boundaries
  localparam int         ADDR_W      = 9;
  localparam int         PAGE_BYTES  = 16;
  localparam logic [8:0] LOCK_QTR    = 9'h180;
  localparam logic [8:0] LOCK_HALF   = 9'h100;

  // Threshold programming sequences
  localparam logic [8:0] TRIP_RAISE_ADDR  = 9'h001;
  localparam logic [8:0] TRIP_NATIVE_ADDR = 9'h003;
  localparam logic [7:0] TRIP_DATA        = 8'h00;

endpackage

// [csw_sup_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface csw_sup_if;
  logic       ce;
  logic       tick;
  logic       watchdog_kick_input;
  logic [1:0] wd_sel;
  logic       wd_expire;
  logic       supply_low;
  logic       rst_active;

  modport core (output ce, watchdog_kick_input, wd_sel, supply_low,
                input  tick, wd_expire, rst_active);
  modport wdog (input  ce, watchdog_kick_input, wd_sel, rst_active,
                output tick, wd_expire);
  modport hold (input  ce, tick, wd_expire, supply_low,
                output rst_active);
endinterface

`default_nettype wire

// [csw_wdog.sv]
`timescale 1ns/1ns
`default_nettype none

module csw_wdog
  import csw_pkg::*;
#(
  parameter int LONG_TICKS  = WD_LONG_TICKS,
  parameter int MID_TICKS   = WD_MID_TICKS,
  parameter int SHORT_TICKS = WD_SHORT_TICKS
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  csw_sup_if.wdog   sup
);

  logic [15:0] pre_cnt;
  logic [31:0] wd_cnt;
  logic [31:0] wd_limit;
  logic        pre_wrap;
  logic        wd_hold;
  logic        wd_hit;

  // Free-running time base, independent of the serial clock
  assign pre_wrap = (pre_cnt == 16'(TICK_CYC - 1));
  assign wd_limit = (sup.wd_sel == WD_SEL_LONG)  ? 32'(LONG_TICKS) :
                    (sup.wd_sel == WD_SEL_MID)   ? 32'(MID_TICKS)  :
                                                    32'(SHORT_TICKS);
  // Counter sits at zero while disabled or while reset is already out
  assign wd_hold  = sup.watchdog_kick_input || (sup.wd_sel == WD_SEL_OFF) ||
                    sup.rst_active;
  assign wd_hit   = sup.tick && (wd_cnt == wd_limit - 32'h1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_cnt  <= 16'h0;
      sup.tick <= 1'b0;
    end else if (sup.ce) begin
      pre_cnt  <= pre_wrap ? 16'h0 : pre_cnt + 16'h1;
      sup.tick <= pre_wrap;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_cnt        <= 32'h0;
      sup.wd_expire <= 1'b0;
    end else if (sup.ce) begin
      sup.wd_expire <= ~wd_hold && wd_hit;
      if (wd_hold || wd_hit) begin
        wd_cnt <= 32'h0;
      end else if (sup.tick) begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end

endmodule

`default_nettype wire

// [csw_hold.sv]
`timescale 1ns/1ns
`default_nettype none

module csw_hold
  import csw_pkg::*;
#(
  parameter int HOLD_TICKS = RST_HOLD_TICKS
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  csw_sup_if.hold   sup
);

  logic [31:0] hold_cnt;
  logic        cause;
  logic        done;

  assign cause = sup.supply_low || sup.wd_expire;
  assign done  = (hold_cnt == 32'(HOLD_TICKS));

  // Count starts at zero, so reset is out from power-up until release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt       <= 32'h0;
      sup.rst_active <= 1'b1;
    end else if (sup.ce) begin
      if (cause) begin
        hold_cnt       <= 32'h0;
        sup.rst_active <= 1'b1;
      end else begin
        if (sup.tick && !done) begin
          hold_cnt <= hold_cnt + 32'h1;
        end
        sup.rst_active <= !done;
      end
    end
  end

endmodule

`default_nettype wire

// [csw_top.sv]
`timescale 1ns/1ns
`default_nettype none

module csw_top
  import csw_pkg::*;
#(
  parameter int   WD_LONG     = WD_LONG_TICKS,
  parameter int   WD_MID      = WD_MID_TICKS,
  parameter int   WD_SHORT    = WD_SHORT_TICKS,
  parameter int   RST_HOLD    = RST_HOLD_TICKS,
  parameter int   WR_CYCLE    = WR_CYCLE_TICKS,
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        chip_sel_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        write_prot_n,
  input  wire logic        write_prot_prog,
  input  wire logic        supply_low,
  input  wire logic [3:0]  nv_ctrl_init,
  input  wire logic [7:0]  array_rdata,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             sup_reset,
  output logic             sup_reset_oe,
  output logic             standby,
  output logic             write_busy,
  output logic             nv_ctrl_we,
  output logic [3:0]       nv_ctrl_data,
  output logic             array_we,
  output logic [8:0]       array_addr,
  output logic [7:0]       array_wdata,
  output logic             trip_raise_start,
  output logic             trip_native_start
);

  typedef enum {CSW_OPC, CSW_ADDR, CSW_WDATA, CSW_SDATA, CSW_RDOUT, CSW_SKIP} csw_state_t;

  csw_sup_if sup ();

  csw_wdog #(
    .LONG_TICKS  (WD_LONG),
    .MID_TICKS   (WD_MID),
    .SHORT_TICKS (WD_SHORT)
  ) u_wdog (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sup     (sup)
  );

  csw_hold #(
    .HOLD_TICKS (RST_HOLD)
  ) u_hold (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sup     (sup)
  );

  csw_state_t state;
  logic        sclk_q;
  logic        cs_q;
  logic [7:0]  in_sr;
  logic [2:0]  bitn;
  logic [2:0]  obit;
  logic [7:0]  out_sr;
  logic        a8;
  logic        rd_stat;
  logic        is_read;
  logic [8:0]  addr;
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [15:0] page_mask;
  logic [4:0]  wr_count;
  logic [7:0]  last_byte;
  logic [7:0]  stat_new;
  logic        stat_full;
  logic        wel;
  logic [3:0]  ctrl;
  logic        ctrl_loaded;
  logic        cyc_arr;
  logic [31:0] busy_cnt;
  logic [4:0]  emit_idx;

  // Edge detection on the synchronous serial pins
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic shift_en;
  logic byte_done;
  logic [7:0] in_byte;
  logic [7:0] opc_a8;
  logic wp_ok;
  logic lock_hit;
  logic commit;
  logic commit_arr;
  logic commit_stat;
  logic cyc_end;
  logic [7:0] stat_byte;
  logic [7:0] rd_byte;
  logic [3:0] page_off;
  logic       single_zero;

  function automatic logic locked(input logic [1:0] bl, input logic [8:0] a);
    case (bl)
      2'h1:    locked = (a >= LOCK_QTR);
      2'h2:    locked = (a >= LOCK_HALF);
      2'h3:    locked = 1'b1;
      default: locked = 1'b0;
    endcase
  endfunction

  assign sclk_rise   = sclk && !sclk_q;
  assign sclk_fall   = !sclk && sclk_q;
  assign cs_fall     = cs_q && !chip_sel_n;
  assign cs_rise     = !cs_q && chip_sel_n;
  assign shift_en    = sclk_rise && !chip_sel_n && (state != CSW_SKIP);
  assign byte_done   = shift_en && (bitn == 3'h7);
  assign in_byte     = {in_sr[6:0], sdi};
  assign opc_a8      = in_byte & OPC_A8_MASK;
  // Programming level on the protect pin counts as protect released
  assign wp_ok       = write_prot_n || write_prot_prog;
  assign lock_hit    = locked(ctrl[1:0], addr);
  assign page_off    = addr[3:0] + wr_count[3:0];
  assign single_zero = (wr_count == 5'h1) && (last_byte == TRIP_DATA);
  // Only whole bytes commit, and never while a cycle still runs
  assign commit_arr  = (state == CSW_WDATA) && (page_mask != 16'h0) && !lock_hit;
  // Sequencer leaves the data state after the status byte, so the flag alone marks it whole
  assign commit_stat = stat_full;
  assign commit      = cs_rise && wel && wp_ok && !write_busy && (bitn == 3'h0) &&
                       (commit_arr || commit_stat);
  assign cyc_end     = write_busy && sup.tick && (busy_cnt == 32'(WR_CYCLE) - 32'h1);
  assign stat_byte   = {2'h0, ctrl, wel, write_busy};
  assign rd_byte     = rd_stat ? stat_byte : array_rdata;

  assign sup.ce                  = ce;
  assign sup.watchdog_kick_input = cs_fall;
  logic watchdog_period_bit0;
  logic watchdog_period_bit1;
  assign watchdog_period_bit0    = ctrl[2];
  assign watchdog_period_bit1    = ctrl[3];
  assign sup.wd_sel              = {watchdog_period_bit1, watchdog_period_bit0};
  assign sup.supply_low          = supply_low;
  assign sup_reset               = RESET_LEVEL;
  assign sup_reset_oe            = sup.rst_active;
  assign sdo_oe                  = !chip_sel_n && (state == CSW_RDOUT);
  assign standby                 = chip_sel_n && !write_busy;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else if (ce) begin
      sclk_q <= sclk;
      cs_q   <= chip_sel_n;
    end
  end

  // Nonvolatile control bits come from the store after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl        <= CTRL_RESET;
      ctrl_loaded <= 1'b0;
    end else if (ce) begin
      ctrl_loaded <= 1'b1;
      if (!ctrl_loaded) begin
        ctrl <= nv_ctrl_init;
      end else if (commit && commit_stat) begin
        ctrl <= stat_new[ST_CTRL_LSB +: CTRL_W];
      end
    end
  end

  // Command sequencer; state starts in skip so nothing runs before a select fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state   <= CSW_SKIP;
      bitn    <= 3'h0;
      in_sr   <= 8'h00;
      a8      <= 1'b0;
      rd_stat <= 1'b0;
      is_read <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        state <= CSW_OPC;
        bitn  <= 3'h0;
      end else if (shift_en) begin
        in_sr <= in_byte;
        bitn  <= bitn + 3'h1;
        if (byte_done) begin
          case (state)
            CSW_OPC: begin
              a8      <= in_byte[OPC_A8_BIT];
              rd_stat <= (in_byte == OPC_STAT_RD);
              is_read <= (opc_a8 == OPC_ARR_RD);
              if (in_byte == OPC_STAT_RD) begin
                state <= CSW_RDOUT;
              end else if (in_byte == OPC_STAT_WR && !write_busy) begin
                state <= CSW_SDATA;
              end else if ((opc_a8 == OPC_ARR_RD || opc_a8 == OPC_ARR_WR) && !write_busy) begin
                state <= CSW_ADDR;
              end else begin
                state <= CSW_SKIP;
              end
            end
            CSW_ADDR:  state <= is_read ? CSW_RDOUT : CSW_WDATA;
            CSW_SDATA: state <= CSW_SKIP;
            default:   state <= state;
          endcase
        end
      end else if (!chip_sel_n && !wp_ok &&
                   (state == CSW_WDATA || state == CSW_SDATA)) begin
        state <= CSW_SKIP;
      end
    end
  end

  // Write latch: protect low clears it, end of a cycle clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wel <= 1'b0;
    end else if (ce) begin
      // A latch-set beats the end-of-cycle clear, so it is lost only while protect is low
      if (!wp_ok) begin
        wel <= 1'b0;
      end else if (byte_done && state == CSW_OPC && in_byte == WRITE_LATCH_SET_CMD) begin
        wel <= 1'b1;
      end else if (cyc_end || (byte_done && state == CSW_OPC && in_byte == OPC_LATCH_CLR)) begin
        wel <= 1'b0;
      end
    end
  end

  // Page collection; offsets wrap inside the page
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr      <= 9'h000;
      page_mask <= 16'h0;
      wr_count  <= 5'h0;
      last_byte <= 8'h00;
      stat_new  <= 8'h00;
      stat_full <= 1'b0;
    end else if (ce) begin
      if (cs_fall || (!wp_ok && !chip_sel_n)) begin
        page_mask <= 16'h0;
        wr_count  <= 5'h0;
        stat_full <= 1'b0;
      end else if (byte_done) begin
        case (state)
          CSW_ADDR: addr <= {a8, in_byte};
          CSW_WDATA: begin
            page_mask[page_off] <= 1'b1;
            last_byte           <= in_byte;
            if (wr_count != 5'(PAGE_BYTES)) begin
              wr_count <= wr_count + 5'h1;
            end
          end
          CSW_SDATA: begin
            stat_new  <= in_byte;
            stat_full <= 1'b1;
          end
          default: addr <= addr;
        endcase
      end else if (state == CSW_RDOUT && !rd_stat && sclk_fall && !chip_sel_n &&
                   obit == 3'h7) begin
        addr <= addr + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && byte_done && state == CSW_WDATA) begin
      page_buf[page_off] <= in_byte;
    end
  end

  // Read path: each bit changes only on a serial clock fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdo    <= 1'b0;
      out_sr <= 8'h00;
      obit   <= 3'h0;
    end else if (ce) begin
      if (byte_done) begin
        obit <= 3'h0;
      end else if (sclk_fall && !chip_sel_n && state == CSW_RDOUT) begin
        obit <= obit + 3'h1;
        if (obit == 3'h0) begin
          sdo    <= rd_byte[7];
          out_sr <= {rd_byte[6:0], 1'b0};
        end else begin
          sdo    <= out_sr[7];
          out_sr <= {out_sr[6:0], 1'b0};
        end
      end
    end
  end

  // Self-timed cycle; protect changes no longer matter once it runs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_busy        <= 1'b0;
      busy_cnt          <= 32'h0;
      cyc_arr           <= 1'b0;
      emit_idx          <= 5'h0;
      nv_ctrl_we        <= 1'b0;
      nv_ctrl_data      <= CTRL_RESET;
      trip_raise_start  <= 1'b0;
      trip_native_start <= 1'b0;
    end else if (ce) begin
      nv_ctrl_we        <= commit && commit_stat;
      trip_raise_start  <= commit && commit_arr && write_prot_prog && single_zero &&
                           (addr == TRIP_RAISE_ADDR);
      trip_native_start <= commit && commit_arr && write_prot_prog && single_zero &&
                           (addr == TRIP_NATIVE_ADDR);
      if (commit) begin
        write_busy   <= 1'b1;
        busy_cnt     <= 32'h0;
        cyc_arr      <= commit_arr;
        emit_idx     <= 5'h0;
        nv_ctrl_data <= stat_new[ST_CTRL_LSB +: CTRL_W];
      end else if (write_busy) begin
        if (emit_idx != 5'(PAGE_BYTES)) begin
          emit_idx <= emit_idx + 5'h1;
        end
        if (cyc_end) begin
          write_busy <= 1'b0;
        end else if (sup.tick) begin
          busy_cnt <= busy_cnt + 32'h1;
        end
      end
    end
  end

  // Array port: page bytes go out one per clock at the start of a cycle
  logic emit_now;
  assign emit_now = write_busy && cyc_arr && (emit_idx != 5'(PAGE_BYTES));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      array_we    <= 1'b0;
      array_addr  <= 9'h000;
      array_wdata <= 8'h00;
    end else if (ce) begin
      array_we <= emit_now && page_mask[emit_idx[3:0]];
      if (emit_now) begin
        array_addr  <= {addr[8:4], emit_idx[3:0]};
        array_wdata <= page_buf[emit_idx[3:0]];
      end else begin
        array_addr  <= addr;
      end
    end
  end

endmodule

`default_nettype wire

// [csw_chk.sv]
`timescale 1ns/1ns
`default_nettype none

module csw_chk
  import csw_pkg::*;
#(
  parameter int   WD_SHORT    = WD_SHORT_TICKS,
  parameter int   RST_HOLD    = RST_HOLD_TICKS,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic sclk,
  input wire logic write_prot_n,
  input wire logic write_prot_prog,
  input wire logic supply_low,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sup_reset,
  input wire logic sup_reset_oe,
  input wire logic standby,
  input wire logic write_busy,
  input wire logic array_we,
  input wire logic trip_raise_start,
  input wire logic trip_native_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Tick phase is free running, so hold figures are checked within one tick
  int   run;
  int   quiet;
  logic cs_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run   <= 0;
      quiet <= 0;
      cs_q  <= 1'b1;
    end else begin
      cs_q  <= chip_sel_n;
      run   <= (sup_reset_oe && !supply_low) ? run + 1 : 0;
      quiet <= (cs_q && !chip_sel_n) ? 0 : quiet + 1;
    end
  end
  desel_off_a: assert property (chip_sel_n && $past(chip_sel_n) |-> !sdo_oe)
    else $error("output enabled while deselected");
  standby_a: assert property (standby |-> (chip_sel_n || $past(chip_sel_n)) && !write_busy)
    else $error("standby while selected or busy");
  low_rst_a: assert property (supply_low |=> sup_reset_oe)
    else $error("low supply without reset");
  rst_lvl_a: assert property (sup_reset == RESET_LEVEL)
    else $error("reset drive level wrong");
  hold_min_a: assert property ($fell(sup_reset_oe) |-> run >= (RST_HOLD - 1) * TICK_CYC)
    else $error("reset released early");
  hold_max_a: assert property (run <= (RST_HOLD + 1) * TICK_CYC)
    else $error("reset held too long");
  wd_min_a: assert property ($rose(sup_reset_oe) |->
    $past(supply_low) || quiet >= (WD_SHORT - 1) * TICK_CYC)
    else $error("reset without cause");
  sdo_edge_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |->
    !$past(sclk) && $past(sclk, 2))
    else $error("read bit moved off a clock fall");
  commit_a: assert property ($rose(write_busy) |->
    $past(chip_sel_n) && ($past(write_prot_n) || $past(write_prot_prog)))
    else $error("write cycle without release or select rise");
  we_busy_a: assert property (array_we |-> write_busy)
    else $error("array write outside cycle");
  raise_a: assert property (trip_raise_start |-> $rose(write_busy) && $past(write_prot_prog))
    else $error("raise start without sequence");
  native_a: assert property (trip_native_start |-> $rose(write_busy) && $past(write_prot_prog))
    else $error("native start without sequence");
  cover property (trip_raise_start);
  cover property (trip_native_start);
  cover property (array_we);
  cover property ($rose(sup_reset_oe) && !supply_low);
endmodule

`default_nettype wire

// [csw_host.sv]
`timescale 1ns/1ns
`default_nettype none

module csw_host (
  input  wire logic ref_clk,
  input  wire logic sdo,
  output var  logic chip_sel_n,
  output var  logic sclk,
  output var  logic sdi
);
  initial begin
    chip_sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Mode 0, clock high 4 cycles and low 5 cycles; input bit changes while the clock is low
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge ref_clk) chip_sel_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (4) @(posedge ref_clk);
      rx = {rx[6:0], sdo};
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    // Idle input shows the inverse so a stale bit is never taken as good
    sdi <= ~sdi;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import csw_pkg::*;
  localparam int HOLD  = 10;
  localparam int SHORT = 20;
  logic        ref_clk;
  logic        rst = 1'b1;
  logic        write_prot_n = 1'b1;
  logic        write_prot_prog = 1'b0;
  logic        supply_low = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  nv_init = 4'hc;
  logic [7:0]  array_rdata = 8'h00;
  logic        chip_sel_n, sclk, sdi, sdo, sdo_oe, sup_reset, sup_reset_oe;
  logic        standby, write_busy, nv_ctrl_we, array_we, trip_raise_start, trip_native_start;
  logic [3:0]  nv_ctrl_data;
  logic [8:0]  array_addr;
  logic [7:0]  array_wdata, rx, d;
  logic [16:0] exq[$];
  logic [31:0] seed = 32'h3cfb;
  logic [8:0]  c_addr[4] = '{9'h110, 9'h020, TRIP_RAISE_ADDR, TRIP_NATIVE_ADDR};
  logic        c_wpn[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic        c_prog[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  int          err_total = 0;
  int          n_compared = 0;
  int          n_raise = 0;
  int          n_native = 0;
  int          n;

  csw_top #(.WD_LONG(40), .WD_MID(30), .WD_SHORT(SHORT), .RST_HOLD(HOLD), .WR_CYCLE(5))
    u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi), .write_prot_n(write_prot_n),
    .write_prot_prog(write_prot_prog), .supply_low(supply_low), .nv_ctrl_init(nv_init),
    .array_rdata(array_rdata), .sdo(sdo), .sdo_oe(sdo_oe), .sup_reset(sup_reset),
    .sup_reset_oe(sup_reset_oe), .standby(standby), .write_busy(write_busy),
    .nv_ctrl_we(nv_ctrl_we), .nv_ctrl_data(nv_ctrl_data), .array_we(array_we),
    .array_addr(array_addr), .array_wdata(array_wdata), .trip_raise_start(trip_raise_start),
    .trip_native_start(trip_native_start));
  csw_host u_host (.ref_clk(ref_clk), .sdo(sdo), .chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_rel(input int lo, input int hi);
    n = 0;
    while (sup_reset_oe !== 1'b0 && n <= hi) begin
      @(posedge ref_clk);
      n++;
    end
    check({16'h0, n >= lo && n <= hi}, 17'h1);
  endtask
  // Protect goes low during the cycle, which also ends a threshold sequence
  task automatic fin();
    write_prot_n <= 1'b0;
    write_prot_prog <= 1'b0;
    @(posedge ref_clk);
    n = 0;
    while (write_busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check({16'h0, write_busy}, 17'h0);
    write_prot_n <= 1'b1;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (array_we || nv_ctrl_we)
      check(nv_ctrl_we ? {13'h0, nv_ctrl_data} : {array_addr, array_wdata},
            exq.size() ? exq.pop_front() : 17'hx);
    n_raise += trip_raise_start;
    n_native += trip_native_start;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    check({16'h0, sup_reset_oe}, 17'h1);
    rst <= 1'b0;
    wait_rel((HOLD - 1) * TICK_CYC, (HOLD + 1) * TICK_CYC);
    u_host.xfer(24'h0, 0, rx);
    u_host.xfer({8'h00, OPC_STAT_RD, 8'h00}, 16, rx);
    check({9'h0, rx}, 17'h030);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = (i < 2) ? seed[7:0] : TRIP_DATA;
      @(posedge ref_clk);
      write_prot_n <= c_wpn[i];
      write_prot_prog <= c_prog[i];
      u_host.xfer({16'h0, WRITE_LATCH_SET_CMD}, 8, rx);
      if (c_wpn[i]) exq.push_back({c_addr[i], d});
      u_host.xfer({OPC_ARR_WR | {4'h0, c_addr[i][8], 3'h0}, c_addr[i][7:0], d}, 24, rx);
      fin();
    end
    check(17'(n_raise), 17'h1);
    check(17'(n_native), 17'h1);
    array_rdata <= seed[15:8];
    u_host.xfer({OPC_ARR_RD | 8'h08, 8'h10, 8'h00}, 24, rx);
    check({9'h0, rx}, {9'h0, seed[15:8]});
    u_host.xfer({16'h0, WRITE_LATCH_SET_CMD}, 8, rx);
    fork
      u_host.xfer({OPC_ARR_WR, 8'h40, seed[23:16]}, 24, rx);
      begin
        repeat (150) @(posedge ref_clk);
        write_prot_n <= 1'b0;
      end
    join
    fin();
    @(posedge ref_clk);
    supply_low <= 1'b1;
    repeat (20) @(posedge ref_clk);
    supply_low <= 1'b0;
    wait_rel((HOLD - 1) * TICK_CYC, (HOLD + 1) * TICK_CYC);
    u_host.xfer({16'h0, WRITE_LATCH_SET_CMD}, 8, rx);
    exq.push_back(17'h8);
    u_host.xfer({8'h00, OPC_STAT_WR, 8'h20}, 16, rx);
    fin();
    // Enable low freezes the block, so this latch-set must go unseen
    ce <= 1'b0;
    u_host.xfer({16'h0, WRITE_LATCH_SET_CMD}, 8, rx);
    ce <= 1'b1;
    @(posedge ref_clk);
    u_host.xfer({8'h00, OPC_STAT_RD, 8'h00}, 16, rx);
    check({9'h0, rx}, 17'h020);
    repeat (3) begin
      repeat ((SHORT - 3) * TICK_CYC) @(posedge ref_clk);
      u_host.xfer(24'h0, 0, rx);
      check({16'h0, sup_reset_oe}, 17'h0);
    end
    n = 0;
    while (sup_reset_oe !== 1'b1 && n < (SHORT + 2) * TICK_CYC) begin
      @(posedge ref_clk);
      n++;
    end
    check({16'h0, n >= (SHORT - 1) * TICK_CYC - 20 && n <= (SHORT + 1) * TICK_CYC}, 17'h1);
    wait_rel((HOLD - 1) * TICK_CYC, (HOLD + 1) * TICK_CYC);
    check(17'(exq.size()), 17'h0);
    results();
  end
endmodule

bind csw_top csw_chk #(.WD_SHORT(WD_SHORT), .RST_HOLD(RST_HOLD), .RESET_LEVEL(RESET_LEVEL))
  u_chk (.ref_clk(ref_clk), .rst(rst), .chip_sel_n(chip_sel_n), .sclk(sclk),
  .write_prot_n(write_prot_n), .write_prot_prog(write_prot_prog), .supply_low(supply_low),
  .sdo(sdo), .sdo_oe(sdo_oe), .sup_reset(sup_reset), .sup_reset_oe(sup_reset_oe),
  .standby(standby), .write_busy(write_busy), .array_we(array_we),
  .trip_raise_start(trip_raise_start), .trip_native_start(trip_native_start));

`default_nettype wire
